/* design/dbte_pkg.sv */
// constants and types for the debug breakpoint, trace and halt-entry block
package dbte_pkg;
   localparam int DATA_W = 16;
   localparam int SEL_W  = 3;

   // ---------------------------------------------------------------
   // test-port register and command selects
   // ---------------------------------------------------------------
   localparam logic [2:0] SEL_BPCTL  = 3'h0;
   localparam logic [2:0] SEL_BPCNT  = 3'h1;
   localparam logic [2:0] SEL_TRCNT  = 3'h2;
   localparam logic [2:0] SEL_DSC    = 3'h3;
   localparam logic [2:0] SEL_GO     = 3'h4;
   localparam logic [2:0] SEL_DBGREQ = 3'h5;

   // ---------------------------------------------------------------
   // breakpoint control fields
   // ---------------------------------------------------------------
   localparam int BP1_ACC_LSB = 6;
   localparam int BP1_CMP_LSB = 8;
   localparam int BP_SEQ_LSB  = 10;
   localparam logic [15:0] BPCTL_MASK = 16'h0fff;
   localparam logic [15:0] ZERO16     = 16'h0000;
   localparam logic [15:0] ONE16      = 16'h0001;

   localparam logic [1:0] ACC_OFF = 2'h0;
   localparam logic [1:0] ACC_WR  = 2'h1;
   localparam logic [1:0] ACC_RD  = 2'h2;
   localparam logic [1:0] ACC_RW  = 2'h3;
   localparam logic [1:0] CMP_NE  = 2'h0;
   localparam logic [1:0] CMP_EQ  = 2'h1;
   localparam logic [1:0] CMP_LT  = 2'h2;
   localparam logic [1:0] CMP_GT  = 2'h3;
   localparam logic [1:0] SEQ_AND = 2'h0;
   localparam logic [1:0] SEQ_OR  = 2'h1;
   localparam logic [1:0] SEQ_1A0 = 2'h2;
   localparam logic [1:0] SEQ_0A1 = 2'h3;

   // ---------------------------------------------------------------
   // debug status and control layout
   // ---------------------------------------------------------------
   localparam int DSC_TME    = 0;
   localparam int DSC_SWO    = 2;
   localparam int DSC_MBO    = 3;
   localparam int DSC_TO     = 4;
   localparam int DSC_OS_LSB = 6;
   localparam logic [1:0] OS_EXEC = 2'h0;
   localparam logic [1:0] OS_WAIT = 2'h1;
   localparam logic [1:0] OS_BUS  = 2'h2;
   localparam logic [1:0] OS_HALT = 2'h3;

   localparam logic [1:0] BOOT_CYCLES = 2'h3;

   typedef struct packed {
      logic              write;
      logic [SEL_W-1:0]  sel;
      logic [DATA_W-1:0] data;
   } dbte_tap_req_type;

   typedef enum logic [1:0] {
      DBTE_BOOT = 2'b00,
      DBTE_RUN  = 2'b01,
      DBTE_HALT = 2'b10
   } dbte_state_type;
endpackage

/* design/dbte_core.sv */
// debug breakpoint sequencing, trace counting and debug halt entry
// Operation
// - bp1 access select bits 6-7: off, write, read, read or write
// - bp1 compare bits 8-9: ne, eq, lt, gt against limit register 1
// - event select bits 10-11: and, or, bp1 after bp0, bp0 after bp1
// - each selected event decrements a non-zero occurrence counter
// - control bits 12-15 read zero; controller writes zeros
// - event with occurrence counter at zero enters debug halt
// - occurrence counter write resets sequencing state
// - occurrence counter test-port accessible, cleared by reset
// - trace counter test-port accessible, reset clears, load N-1
// - trace counts every executed instruction, interrupts still served
// - trace at zero halts, sets trace flag, status 11, drives line
// - every halt entry updates status and drives debug line
// - protected option keeps block idle until debug data write
// - line held low in reset gives halt with no instruction run
// - line request halts when next instruction enters latch
// - test-port request behaves like the line request
// - request in stop or wait wakes core then halts at latch
// - software halt instruction halts when next enters latch
// - status field: 00 exec, 01 wait/stop, 10 bus wait, 11 halt
// - tracing active only while trace enable bit is set
`timescale 1ns/10ps
module dbte_core #(
   parameter bit PROTECT_EN = 1'b0
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       link_clk_i,
   input  wire logic                       tap_req_i,
   input  wire dbte_pkg::dbte_tap_req_type tap_cmd_i,
   output logic                            tap_busy_o,
   output logic                            tap_done_o,
   output logic [dbte_pkg::DATA_W-1:0]     tap_rdata_o,
   input  wire logic                       dbg_line_i,
   output logic                            dbg_line_o,
   output logic                            dbg_line_oe_o,
   input  wire logic                       instr_done_i,
   input  wire logic                       latch_load_i,
   input  wire logic                       mem_read_i,
   input  wire logic                       mem_write_i,
   input  wire logic [dbte_pkg::DATA_W-1:0] mem_addr_i,
   input  wire logic [dbte_pkg::DATA_W-1:0] limit1_i,
   input  wire logic                       bp0_hit_i,
   input  wire logic                       sw_halt_i,
   input  wire logic                       wait_stop_i,
   input  wire logic                       bus_wait_i,
   input  wire logic                       gdb_write_i,
   output logic                            halt_o,
   output logic                            wake_o,
   output logic [1:0]                      core_status_o
);
   import dbte_pkg::*;

   localparam int LINK_MIN = 3;
   localparam int LINK_MAX = 20;

   // ---------------------------------------------------------------
   // link domain: request hold and answer capture
   // ---------------------------------------------------------------
   dbte_tap_req_type  req_hold_r;
   logic              req_tgl_r;
   logic              busy_r;
   logic              done_r;
   logic [DATA_W-1:0] rdata_r;
   logic              ak_s1_r, ak_s2_r, ak_s3_r, ak_seen_r;
   logic              ack_tgl_r;
   logic [DATA_W-1:0] rd_r;
   wire               link_take = tap_req_i && !busy_r;
   wire               ack_evt   = (ak_s2_r == ak_s3_r) &&
                                  (ak_s3_r != ak_seen_r);

   always_ff @(posedge link_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         req_hold_r <= '0;
         req_tgl_r  <= 1'b0;
         busy_r     <= 1'b0;
         done_r     <= 1'b0;
         rdata_r    <= ZERO16;
         ak_s1_r    <= 1'b0;
         ak_s2_r    <= 1'b0;
         ak_s3_r    <= 1'b0;
         ak_seen_r  <= 1'b0;
      end
      else
      begin
         ak_s1_r <= ack_tgl_r;
         ak_s2_r <= ak_s1_r;
         ak_s3_r <= ak_s2_r;
         done_r  <= ack_evt;
         if (ack_evt)
         begin
            ak_seen_r <= ak_s3_r;
            rdata_r   <= rd_r;
            busy_r    <= 1'b0;
         end
         else if (link_take)
         begin
            req_hold_r <= tap_cmd_i;
            req_tgl_r  <= ~req_tgl_r;
            busy_r     <= 1'b1;
         end
      end
   end

   assign tap_busy_o  = busy_r;
   assign tap_done_o  = done_r;
   assign tap_rdata_o = rdata_r;

   // ---------------------------------------------------------------
   // core domain: synchronisers
   // ---------------------------------------------------------------
   logic rq_s1_r, rq_s2_r, rq_s3_r, rq_seen_r;
   logic ln_s1_r, ln_s2_r, ln_s3_r;
   wire  req_evt  = (rq_s2_r == rq_s3_r) && (rq_s3_r != rq_seen_r);
   wire  line_low = !ln_s2_r && !ln_s3_r;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rq_s1_r   <= 1'b0;
         rq_s2_r   <= 1'b0;
         rq_s3_r   <= 1'b0;
         rq_seen_r <= 1'b0;
         ln_s1_r   <= 1'b1;
         ln_s2_r   <= 1'b1;
         ln_s3_r   <= 1'b1;
      end
      else
      begin
         rq_s1_r <= req_tgl_r;
         rq_s2_r <= rq_s1_r;
         rq_s3_r <= rq_s2_r;
         ln_s1_r <= dbg_line_i;
         ln_s2_r <= ln_s1_r;
         ln_s3_r <= ln_s2_r;
         if (req_evt)
            rq_seen_r <= rq_s3_r;
      end
   end

   // ---------------------------------------------------------------
   // registers and decode
   // ---------------------------------------------------------------
   dbte_state_type    state_r, state_nxt;
   logic [1:0]        boot_cnt_r;
   logic              active_r;
   logic [DATA_W-1:0] bpctl_r, bpcnt_r, trcnt_r;
   logic              tme_r, swo_r, mbo_r, to_r;
   logic              armed0_r, armed1_r;
   logic              pend_r, sw_pend_r, bp_pend_r;
   logic              oe_r, halt_r, wake_r;
   logic [1:0]        status_r;

   wire run   = (state_r == DBTE_RUN) && active_r;
   wire halted = (state_r == DBTE_HALT);
   wire cmd_ok = req_evt && active_r;
   wire wr_ok  = cmd_ok && req_hold_r.write;
   wire sel_bpctl = wr_ok && (req_hold_r.sel == SEL_BPCTL);
   wire sel_bpcnt = wr_ok && (req_hold_r.sel == SEL_BPCNT);
   wire sel_trcnt = wr_ok && (req_hold_r.sel == SEL_TRCNT);
   wire sel_dsc   = wr_ok && (req_hold_r.sel == SEL_DSC);
   wire sel_go    = cmd_ok && (req_hold_r.sel == SEL_GO) && halted;
   wire sel_dreq  = cmd_ok && (req_hold_r.sel == SEL_DBGREQ);

   wire [1:0] acc = bpctl_r[BP1_ACC_LSB +: 2];
   wire [1:0] cmp = bpctl_r[BP1_CMP_LSB +: 2];
   wire [1:0] seq = bpctl_r[BP_SEQ_LSB +: 2];

   wire acc_hit = ((acc == ACC_WR) && mem_write_i) ||
                  ((acc == ACC_RD) && mem_read_i)  ||
                  ((acc == ACC_RW) && (mem_read_i || mem_write_i));
   wire cmp_hit = (cmp == CMP_NE) ? (mem_addr_i != limit1_i) :
                  (cmp == CMP_EQ) ? (mem_addr_i == limit1_i) :
                  (cmp == CMP_LT) ? (mem_addr_i <  limit1_i) :
                                    (mem_addr_i >  limit1_i);
   wire b1 = run && acc_hit && cmp_hit;
   wire b0 = run && bp0_hit_i;
   wire seq_evt = (seq == SEQ_AND) ? (b0 && b1) :
                  (seq == SEQ_OR)  ? (b0 || b1) :
                  (seq == SEQ_1A0) ? (b1 && armed0_r) :
                                     (b0 && armed1_r);
   wire bp_zero = (bpcnt_r == ZERO16);
   wire bp_fire = seq_evt && bp_zero;
   wire [DATA_W-1:0] bpcnt_nxt =
      sel_bpcnt ? req_hold_r.data :
      (seq_evt && !bp_zero) ? bpcnt_r - ONE16 : bpcnt_r;
   wire armed0_nxt = !sel_bpcnt && !seq_evt && (armed0_r || b0);
   wire armed1_nxt = !sel_bpcnt && !seq_evt && (armed1_r || b1);

   wire tr_step = run && tme_r && instr_done_i;
   wire tr_zero = (trcnt_r == ZERO16);
   wire tr_fire = tr_step && tr_zero;
   wire [DATA_W-1:0] trcnt_nxt =
      sel_trcnt ? req_hold_r.data :
      (tr_step && !tr_zero) ? trcnt_r - ONE16 : trcnt_r;

   wire ext_req  = run && line_low && !oe_r;
   wire halt_req = pend_r || sw_pend_r || bp_pend_r;
   wire enter    = run && (tr_fire || (latch_load_i && halt_req));
   wire boot_done = (state_r == DBTE_BOOT) && (boot_cnt_r == BOOT_CYCLES);
   wire boot_halt = boot_done && active_r && line_low;

   wire [DATA_W-1:0] dsc_word =
      (DATA_W'(tme_r) << DSC_TME) | (DATA_W'(swo_r) << DSC_SWO) |
      (DATA_W'(mbo_r) << DSC_MBO) | (DATA_W'(to_r) << DSC_TO) |
      (DATA_W'(status_r) << DSC_OS_LSB);
   wire [DATA_W-1:0] rd_nxt =
      !active_r                       ? ZERO16  :
      (req_hold_r.sel == SEL_BPCTL)   ? bpctl_r :
      (req_hold_r.sel == SEL_BPCNT)   ? bpcnt_r :
      (req_hold_r.sel == SEL_TRCNT)   ? trcnt_r :
      (req_hold_r.sel == SEL_DSC)     ? dsc_word : ZERO16;

   // ---------------------------------------------------------------
   // halt state machine
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         DBTE_BOOT:
            if (boot_done)
               state_nxt = boot_halt ? DBTE_HALT : DBTE_RUN;
         DBTE_RUN:
            if (enter)
               state_nxt = DBTE_HALT;
         DBTE_HALT:
            if (sel_go)
               state_nxt = DBTE_RUN;
         default:
            state_nxt = DBTE_RUN;
      endcase
   end

   wire to_halt = (state_nxt == DBTE_HALT);
   wire [1:0] os_nxt = to_halt     ? OS_HALT :
                       wait_stop_i ? OS_WAIT :
                       bus_wait_i  ? OS_BUS  : OS_EXEC;

   // ---------------------------------------------------------------
   // core domain state
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r    <= DBTE_BOOT;
         boot_cnt_r <= 2'h0;
         active_r   <= !PROTECT_EN;
         bpctl_r    <= ZERO16;
         bpcnt_r    <= ZERO16;
         trcnt_r    <= ZERO16;
         armed0_r   <= 1'b0;
         armed1_r   <= 1'b0;
         tme_r      <= 1'b0;
         ack_tgl_r  <= 1'b0;
         rd_r       <= ZERO16;
      end
      else
      begin
         state_r  <= state_nxt;
         bpcnt_r  <= bpcnt_nxt;
         trcnt_r  <= trcnt_nxt;
         armed0_r <= armed0_nxt;
         armed1_r <= armed1_nxt;
         if (state_r == DBTE_BOOT)
            boot_cnt_r <= boot_cnt_r + 2'h1;
         if (gdb_write_i)
            active_r <= 1'b1;
         if (sel_bpctl)
            bpctl_r <= req_hold_r.data & BPCTL_MASK;
         if (sel_dsc)
            tme_r <= req_hold_r.data[DSC_TME];
         if (req_evt)
         begin
            rd_r      <= rd_nxt;
            ack_tgl_r <= ~ack_tgl_r;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pend_r    <= 1'b0;
         sw_pend_r <= 1'b0;
         bp_pend_r <= 1'b0;
         swo_r     <= 1'b0;
         mbo_r     <= 1'b0;
         to_r      <= 1'b0;
      end
      else
      begin
         pend_r    <= run && !enter && (pend_r || ext_req ||
                      sel_dreq);
         sw_pend_r <= run && !enter && (sw_pend_r || sw_halt_i);
         bp_pend_r <= run && !enter && (bp_pend_r || bp_fire);
         if (sel_go)
         begin
            swo_r <= 1'b0;
            mbo_r <= 1'b0;
            to_r  <= 1'b0;
         end
         else if (enter)
         begin
            swo_r <= sw_pend_r;
            mbo_r <= bp_pend_r;
            to_r  <= tr_fire;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         oe_r     <= 1'b0;
         halt_r   <= 1'b0;
         wake_r   <= 1'b0;
         status_r <= OS_EXEC;
      end
      else
      begin
         halt_r   <= to_halt;
         status_r <= os_nxt;
         wake_r   <= run && pend_r && wait_stop_i;
         if (enter || boot_halt)
            oe_r <= 1'b1;
         else if (req_evt || !to_halt)
            oe_r <= 1'b0;
      end
   end

   assign dbg_line_o    = 1'b0;
   assign dbg_line_oe_o = oe_r;
   assign halt_o        = halt_r;
   assign wake_o        = wake_r;
   assign core_status_o = status_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_bp_count_dec: assert property (@(posedge core_clk_i) disable iff (rst_i)
      seq_evt && !bp_zero && !sel_bpcnt |=> bpcnt_r == $past(bpcnt_r) - ONE16)
      else $error("occurrence counter missed a decrement");
   a_bp_zero_pend: assert property (@(posedge core_clk_i) disable iff (rst_i)
      bp_fire && !enter |=> bp_pend_r && bpcnt_r == ZERO16)
      else $error("breakpoint at zero did not request halt");
   a_trace_halt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      tr_fire |=> halt_r && to_r && status_r == OS_HALT && oe_r)
      else $error("trace zero did not halt with flag and line");
   a_halt_ack: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(halt_r) |-> status_r == OS_HALT && oe_r)
      else $error("halt entry not acknowledged");
   a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      bpctl_r[15:12] == 4'h0)
      else $error("reserved control bits not zero");
   a_frozen_halt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      halted && !req_evt |=> $stable(trcnt_r) && $stable(bpcnt_r))
      else $error("counter changed during halt");
   a_seq_reset: assert property (@(posedge core_clk_i) disable iff (rst_i)
      sel_bpcnt |=> !armed0_r && !armed1_r && bpcnt_r == $past(req_hold_r.data))
      else $error("counter write did not reset sequencing");
   a_trace_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !tme_r && !sel_trcnt |=> $stable(trcnt_r))
      else $error("trace counter moved with trace disabled");
   a_latch_halt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run && latch_load_i && halt_req |=> halt_r ##1 status_r == OS_HALT)
      else $error("pending request did not halt at latch load");
   a_protect_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !active_r |-> !halt_r && !oe_r)
      else $error("protected block acted before unlock");
   a_wake_stop: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run && pend_r && wait_stop_i && !enter |=> wake_o)
      else $error("request in stop or wait did not wake core");
   a_link_done: assert property (@(posedge link_clk_i) disable iff (rst_i)
      link_take |-> ##[LINK_MIN:LINK_MAX] done_r)
      else $error("test-port access not answered");
endmodule // dbte_core

/* dv/dbte_ctrl_model.sv */
// controller model: test-port accesses and debug line pull
`timescale 1ns/10ps
module dbte_ctrl_model
(
   input  wire logic                  link_clk_i,
   input  wire logic                  tap_busy_i,
   input  wire logic                  tap_done_i,
   output logic                       tap_req_o,
   output dbte_pkg::dbte_tap_req_type tap_cmd_o,
   output logic                       pull_o
);
   import dbte_pkg::*;
   int n;
   initial
   begin
      tap_req_o = 1'b0;
      tap_cmd_o = '0;
      pull_o    = 1'b0;
   end
   // -------------------------------------------------------------
   // one access at a time, command held until the answer
   // -------------------------------------------------------------
   task automatic access(input logic w, input logic [2:0] s,
                         input logic [15:0] d);
      @(posedge link_clk_i);
      while (tap_busy_i !== 1'b0)
         @(posedge link_clk_i);
      tap_req_o <= 1'b1;
      tap_cmd_o <= '{w, s, d};
      @(posedge link_clk_i);
      tap_req_o <= 1'b0;
      for (n = 0; n < 40 && tap_done_i !== 1'b1; n++)
         @(negedge link_clk_i);
      @(posedge link_clk_i);
      tap_cmd_o.data <= ~d;
   endtask
   // line pull; released before any command follows
   task automatic pull(input logic v);
      @(posedge link_clk_i);
      pull_o <= v;
   endtask
endmodule // dbte_ctrl_model

/* dv/dbte_core_tb.sv */
// testbench: test-port registers, halt entries, trace, breakpoints
`timescale 1ns/10ps
module dbte_core_tb;
   import dbte_pkg::*;
   logic             core_clk_i = 1'b0;
   logic             link_clk_i = 1'b0;
   logic             rst_i      = 1'b1;
   logic             tap_req;
   dbte_tap_req_type tap_cmd;
   logic             tap_busy_o, tap_done_o, pull;
   logic [15:0]      tap_rdata_o;
   logic             line_o, line_oe, line;
   logic [2:0]       ev         = 3'h0;
   logic             mem_rd     = 1'b0;
   logic             mem_wr     = 1'b0;
   logic [15:0]      addr       = 16'h0000;
   logic [15:0]      limit      = 16'h0000;
   logic             bp0        = 1'b0;
   logic             ws         = 1'b0;
   logic             bw         = 1'b0;
   logic             gdb        = 1'b0;
   logic             halt_o, wake_o;
   logic [1:0]       status;
   logic [16:0]      exp_q[$];
   logic [16:0]      nt;
   logic [31:0]      rnd;
   int               fail_count = 0;
   int               cmp_count  = 0;
   int               cyc_n      = 0;
   int               i;

   always #20 core_clk_i = ~core_clk_i;
   always
   begin
      #3;
      forever #32 link_clk_i = ~link_clk_i;
   end
   assign line = (line_oe | pull) ? line_o : 1'b1;

   dbte_ctrl_model u_ctrl (.link_clk_i(link_clk_i),
      .tap_busy_i(tap_busy_o), .tap_done_i(tap_done_o),
      .tap_req_o(tap_req), .tap_cmd_o(tap_cmd), .pull_o(pull));

   dbte_core #(.PROTECT_EN(1'b1)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .link_clk_i(link_clk_i), .tap_req_i(tap_req),
      .tap_cmd_i(tap_cmd), .tap_busy_o(tap_busy_o),
      .tap_done_o(tap_done_o), .tap_rdata_o(tap_rdata_o),
      .dbg_line_i(line), .dbg_line_o(line_o),
      .dbg_line_oe_o(line_oe), .instr_done_i(ev[0]),
      .latch_load_i(ev[1]), .mem_read_i(mem_rd),
      .mem_write_i(mem_wr), .mem_addr_i(addr), .limit1_i(limit),
      .bp0_hit_i(bp0), .sw_halt_i(ev[2]), .wait_stop_i(ws),
      .bus_wait_i(bw), .gdb_write_i(gdb), .halt_o(halt_o),
      .wake_o(wake_o), .core_status_o(status));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e)
      begin
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
         fail_count++;
      end
   endtask
   task automatic rd(input logic [2:0] s, input logic [15:0] e);
      exp_q.push_back({1'b1, e});
      u_ctrl.access(1'b0, s, ZERO16);
   endtask
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      exp_q.push_back({1'b0, d});
      u_ctrl.access(1'b1, s, d);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(posedge core_clk_i);
      ev <= v;
      @(posedge core_clk_i);
      ev <= 3'h0;
   endtask
   task automatic bus(input logic r, input logic w,
                      input logic [15:0] a, input logic b);
      @(posedge core_clk_i);
      {mem_rd, mem_wr, addr, bp0} <= {r, w, a, b};
      @(posedge core_clk_i);
      {mem_rd, mem_wr, bp0} <= 3'h0;
   endtask
   task automatic wait_halt(input logic e);
      for (i = 0; i < 60 && halt_o !== e; i++)
         @(negedge core_clk_i);
      chk(16'(halt_o), 16'(e));
   endtask
   task final_report;
      if (fail_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // read answers compared against the oldest note
   always @(posedge link_clk_i)
      if (tap_done_o === 1'b1 && exp_q.size() > 0)
      begin
         nt = exp_q.pop_front();
         if (nt[16])
            chk(tap_rdata_o, nt[15:0]);
      end

   always @(posedge core_clk_i)
   begin
      cyc_n++;
      if (cyc_n == 20000)
      begin
         fail_count++;
         final_report();
      end
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial
   begin
      rnd = $urandom(56);
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      settle(8);
      chk(16'(status), 16'(OS_EXEC));
      wr(SEL_BPCNT, ONE16);
      rd(SEL_BPCNT, ZERO16);
      @(posedge core_clk_i);
      gdb <= 1'b1;
      @(posedge core_clk_i);
      gdb <= 1'b0;
      rd(SEL_BPCTL, ZERO16);
      rd(SEL_BPCNT, ZERO16);
      rd(SEL_TRCNT, ZERO16);
      wr(SEL_BPCTL, 16'hffff);
      rd(SEL_BPCTL, BPCTL_MASK);
      rnd = $urandom;
      wr(SEL_BPCNT, rnd[15:0]);
      rd(SEL_BPCNT, rnd[15:0]);
      wr(SEL_TRCNT, rnd[31:16]);
      rd(SEL_TRCNT, rnd[31:16]);
      bw <= 1'b1;
      settle(4);
      chk(16'(status), 16'(OS_BUS));
      bw <= 1'b0;
      u_ctrl.pull(1'b1);
      settle(10);
      chk(16'(halt_o), ZERO16);
      pulse(3'h2);
      wait_halt(1'b1);
      chk(16'(status), 16'(OS_HALT));
      chk(16'(line_oe), ONE16);
      u_ctrl.pull(1'b0);
      rd(SEL_DSC, 16'h00c0);
      wr(SEL_DSC, ONE16);
      pulse(3'h1);
      rd(SEL_TRCNT, rnd[31:16]);
      wr(SEL_TRCNT, 16'h0002);
      wr(SEL_GO, ZERO16);
      wait_halt(1'b0);
      pulse(3'h1);
      pulse(3'h1);
      settle(1);
      chk(16'(halt_o), ZERO16);
      pulse(3'h1);
      wait_halt(1'b1);
      chk(16'(line_oe), ONE16);
      chk(16'(line), ZERO16);
      rd(SEL_DSC, 16'h00d1);
      wr(SEL_DSC, ZERO16);
      wr(SEL_GO, ZERO16);
      wait_halt(1'b0);
      pulse(3'h1);
      settle(2);
      chk(16'(halt_o), ZERO16);
      limit <= rnd[15:0] | 16'h8000;
      wr(SEL_BPCTL, 16'h05c0);
      rd(SEL_BPCTL, 16'h05c0);
      wr(SEL_BPCNT, 16'h0002);
      bus(1'b1, 1'b0, limit + 16'h0001, 1'b0);
      bus(1'b0, 1'b1, limit, 1'b0);
      bus(1'b0, 1'b0, limit, 1'b1);
      rd(SEL_BPCNT, ZERO16);
      bus(1'b1, 1'b0, limit, 1'b0);
      settle(2);
      chk(16'(halt_o), ZERO16);
      pulse(3'h2);
      wait_halt(1'b1);
      rd(SEL_DSC, 16'h00c8);
      wr(SEL_BPCTL, 16'h0a40);
      wr(SEL_BPCNT, ZERO16);
      wr(SEL_GO, ZERO16);
      wait_halt(1'b0);
      bus(1'b0, 1'b0, 16'h0000, 1'b1);
      wr(SEL_BPCNT, ZERO16);
      bus(1'b0, 1'b1, 16'h0000, 1'b0);
      bus(1'b0, 1'b0, 16'h0000, 1'b1);
      bus(1'b1, 1'b0, 16'h0000, 1'b0);
      pulse(3'h2);
      settle(2);
      chk(16'(halt_o), ZERO16);
      bus(1'b0, 1'b1, 16'h0000, 1'b0);
      pulse(3'h2);
      wait_halt(1'b1);
      rd(SEL_DSC, 16'h00c8);
      wr(SEL_GO, ZERO16);
      wait_halt(1'b0);
      ws <= 1'b1;
      settle(4);
      chk(16'(status), 16'(OS_WAIT));
      wr(SEL_DBGREQ, ZERO16);
      for (i = 0; i < 60 && wake_o !== 1'b1; i++)
         @(negedge core_clk_i);
      chk(16'(wake_o), ONE16);
      ws <= 1'b0;
      settle(2);
      chk(16'(halt_o), ZERO16);
      pulse(3'h2);
      wait_halt(1'b1);
      wr(SEL_GO, ZERO16);
      wait_halt(1'b0);
      pulse(3'h4);
      settle(2);
      chk(16'(halt_o), ZERO16);
      pulse(3'h2);
      wait_halt(1'b1);
      rd(SEL_DSC, 16'h00c4);
      wr(SEL_TRCNT, rnd[31:16] | ONE16);
      u_ctrl.pull(1'b1);
      settle(4);
      rst_i <= 1'b1;
      settle(5);
      chk(16'(halt_o), ZERO16);
      rst_i <= 1'b0;
      gdb   <= 1'b1;
      @(posedge core_clk_i);
      gdb <= 1'b0;
      wait_halt(1'b1);
      chk(16'(status), 16'(OS_HALT));
      u_ctrl.pull(1'b0);
      rd(SEL_TRCNT, ZERO16);
      settle(2);
      chk(16'(exp_q.size()), ZERO16);
      final_report();
   end
endmodule // dbte_core_tb
